// file: ppio_board_model.sv
// Board-side model of the port pins: wire resolution with pull-ups.
// Assumes the bench sets what external parts drive onto each pin.
`timescale 1ns/1ns

module ppio_board_model (
    input  wire logic [3:0][7:0] pinOut, // design level
    input  wire logic [3:0][7:0] pinOe,  // design enable
    input  wire logic [3:0][7:0] extLvl, // external level
    input  wire logic [3:0][7:0] extEn,  // external enable
    output logic [3:0][7:0]      pinIn   // resolved level
);
    // Undriven pins float up through board pull-ups
    assign pinIn = (pinOe & pinOut) | (~pinOe & extEn & extLvl) | (~pinOe & ~extEn);
endmodule

// file: ppio_monitor.sv
// Checker for the port I/O control block, attached by bind.
// Assumes it sees only the top ports; shadows the power registers.
`timescale 1ns/1ns

module ppio_monitor (
    input wire logic                    sys_clk,      // clock
    input wire logic                    reset_n,      // sync reset
    input wire ppio_pkg::ppio_reg_req_t regReq,       // register access
    input wire logic [7:0]              regRdData,    // read data
    input wire logic [15:0]             cpuAddr,      // core address
    input wire ppio_pkg::ppio_strobe_t  cpuStrobe,    // core strobes
    input wire logic [3:0][7:0]         pldOutSel,    // array output pins
    input wire logic [3:0][7:0]         arrayPinOut,  // array levels
    input wire logic [3:0][7:0]         arrayPinOe,   // array enables
    input wire logic [3:0][7:0]         pinOut,       // drive level
    input wire logic [3:0][7:0]         pinOe,        // drive enable
    input wire ppio_pkg::ppio_array_in_t arrayIn,     // array bus
    input wire logic                    arrayStandby  // standby
);
    import ppio_pkg::*;
    logic [7:0]     pwr1_q, pwr1_d, pwr3_q, pwr3_d;
    logic [4:0]     stab_q, stab_d;
    ppio_array_in_t prevIn_q;

    always_comb begin
        pwr1_d = pwr1_q;
        pwr3_d = pwr3_q;
        if (regReq.wr && regReq.addr == OFF_PMMR_FIRST) pwr1_d = regReq.wdata;
        if (regReq.wr && regReq.addr == OFF_PMMR_THIRD) pwr3_d = regReq.wdata;
        // Saturates so a long quiet spell cannot wrap
        stab_d = (arrayIn != prevIn_q) ? 5'h00 : stab_q + 5'((stab_q != 5'h1f));
        if (!reset_n) begin
            pwr1_d = 8'h00;
            pwr3_d = 8'h00;
        end
    end

    always_ff @(posedge sys_clk) begin
        pwr1_q   <= pwr1_d;
        pwr3_q   <= pwr3_d;
        stab_q   <= stab_d;
        prevIn_q <= arrayIn;
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_turbo_awake: assert property (
        !pwr1_q[TURBO_BIT] |=> !arrayStandby) else $error("standby with turbo on");
    a_standby_count: assert property (
        $rose(arrayStandby) |-> stab_q >= 5'h11) else $error("standby too early");
    a_standby_wake: assert property (
        $changed(arrayIn) |=> !arrayStandby) else $error("standby kept after change");
    a_ale_blocked: assert property (
        pwr1_q[BLK_ALE_BIT] |=> !arrayIn.strobe.ale) else $error("ale not blocked");
    a_rd_blocked: assert property (
        pwr3_q[BLK_RD_BIT] |=> !arrayIn.strobe.rd) else $error("rd not blocked");
    a_wr_passes: assert property (
        !pwr3_q[BLK_WR_BIT] |=> arrayIn.strobe.wr == $past(cpuStrobe.wr))
        else $error("wr strobe lost");
    a_addr_passes: assert property (
        1'b1 |=> arrayIn.addr == $past(cpuAddr)) else $error("address lost");
    a_oe_array: assert property (
        arrayPinOe[1][0] |=> pinOe[1][0]) else $error("array enable ignored");
    a_oe_absent: assert property (
        pinOe[3][0] == 1'b0 && pinOe[2][1:0] == 2'b00) else $error("absent pin driven");
    a_pld_level: assert property (
        pldOutSel[0][1] |=> pinOut[0][1] == $past(arrayPinOut[0][1]))
        else $error("array output level lost");
    a_dird_read: assert property (
        regReq.rd && regReq.addr == OFF_DIR_D |=> (regRdData & 8'hf9) == 8'h00)
        else $error("unused direction bits read");
endmodule

bind ppio_port_io_control ppio_monitor i_ppio_monitor (
    .sys_clk(sys_clk), .reset_n(reset_n), .regReq(regReq), .regRdData(regRdData),
    .cpuAddr(cpuAddr), .cpuStrobe(cpuStrobe), .pldOutSel(pldOutSel),
    .arrayPinOut(arrayPinOut), .arrayPinOe(arrayPinOe), .pinOut(pinOut),
    .pinOe(pinOe), .arrayIn(arrayIn), .arrayStandby(arrayStandby));

// file: ppio_pkg.sv
// Package for the logic-array port I/O control block.
// Assumes one 250 MHz clock shared by the core register port and the block.
package ppio_pkg;

    // ------------------------------------------------------------
    // Port geometry
    // ------------------------------------------------------------
    localparam int unsigned NPORT = 4;
    localparam int unsigned PORT_D = 3;

    // Pins that exist per port, index 0..3 = A, B, C, D
    localparam logic [3:0][7:0] PORT_PIN_MASK = {8'h06, 8'h9C, 8'hFF, 8'hFF};

    // ------------------------------------------------------------
    // Register offsets (register port address space)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_DATA_IN    = 8'h00; // + port index
    localparam logic [7:0] OFF_DATA_OUT   = 8'h04; // + port index
    localparam logic [7:0] OFF_DIR        = 8'h12; // + port index
    localparam logic [7:0] OFF_DIR_D      = 8'h15; // port_d_direction
    localparam logic [7:0] OFF_PMMR_FIRST = 8'hB0; // power_mgmt_reg_first
    localparam logic [7:0] OFF_PMMR_THIRD = 8'hB4; // power_mgmt_reg_third

    // ------------------------------------------------------------
    // Field positions and writable masks
    // ------------------------------------------------------------
    localparam int unsigned TURBO_BIT    = 3; // first reg
    localparam int unsigned BLK_ALE_BIT  = 1; // first reg
    localparam int unsigned BLK_RD_BIT   = 3; // third reg
    localparam int unsigned BLK_WR_BIT   = 4; // third reg
    localparam int unsigned BLK_PROGRAM_STORE_STROBE_BIT = 5; // third reg
    localparam logic [7:0] PMMR_FIRST_MASK = 8'h0A;
    localparam logic [7:0] PMMR_THIRD_MASK = 8'h38;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] DIR_RESET      = 8'h00;
    localparam logic [7:0] DATA_OUT_RESET = 8'h00;
    localparam logic [7:0] PMMR_RESET     = 8'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned STANDBY_NS    = 70;
    localparam logic [4:0] STANDBY_CYC =
        5'((STANDBY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic program_store_strobe; // program_store_strobe
        logic ale;
    } ppio_strobe_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ppio_reg_req_t;

    typedef struct packed {
        logic [15:0]  addr;
        ppio_strobe_t strobe;
        logic         coreReset;
        logic         autoPowerdown;
        logic [7:0]   portA;
        logic [7:0]   portB;
        logic [3:0]   portC;      // pins 7,4,3,2
        logic [1:0]   portD;      // pins 2,1
        logic [7:0]   pageBits;
        logic [7:0]   fbAb;
        logic [7:0]   fbBc;
        logic         flashReady;
    } ppio_array_in_t;

endpackage

// file: ppio_port_io_control.sv
// Port pin glue between the board pins and both logic arrays.
// Assumes the arrays and their config live outside; core reaches
// registers through a one-cycle read/write register port.
//
// Operation
// - Bit 3 of first power register set turns turbo off, allowing standby.
// - Turbo off: arrays go standby after all inputs steady about 70 ns.
// - Turbo bit resets to zero, turbo on by default.
// - Four bits in first and third power registers block core strobes.
// - Arrays see address, strobes, resets, ports, pages, feedback, ready bit.
// - Ports A, B, C enter through input macrocells; port D goes direct.
// - Ports A-C driven by output macrocells; port D by decode chip selects.
// - Array output pins are unavailable for core-controlled I/O; the direction bit still enables their drive here.
// - Array input pins stay readable; direction bit still acts on them.
// - Data-out writes do not reach array output pins.
// - Pin output enable is array enable OR direction bit.
// - Directions reset to 00h; array enable can still drive the pin.
// - Port D direction at 15h: bits 1 and 2 only, one means output.
`timescale 1ns/1ns

module ppio_port_io_control (
    input  wire logic                    sys_clk,       // 250 MHz clock
    input  wire logic                    reset_n,       // sync reset
    input  wire ppio_pkg::ppio_reg_req_t regReq,        // register access
    output logic [7:0]                   regRdData,     // read data, +1 cycle
    input  wire logic [15:0]             cpuAddr,       // core address
    input  wire ppio_pkg::ppio_strobe_t  cpuStrobe,     // core strobes, high = active
    input  wire logic                    coreReset,     // core reset
    input  wire logic                    autoPowerdown, // auto_powerdown_signal
    input  wire logic [7:0]              pageBits,      // page_bits
    input  wire logic [7:0]              mcellFbAb,     // macrocell_bank_ab_feedback
    input  wire logic [7:0]              mcellFbBc,     // macrocell_bank_bc_feedback
    input  wire logic                    flashReady,    // flash ready/busy
    input  wire logic [3:0][7:0]         pldOutSel,     // pin is array output
    input  wire logic [3:0][7:0]         arrayPinOut,   // array pin levels
    input  wire logic [3:0][7:0]         arrayPinOe,    // array enable terms
    input  wire logic [3:0][7:0]         pinIn,         // board pin levels
    output logic [3:0][7:0]              pinOut,        // pin drive level
    output logic [3:0][7:0]              pinOe,         // pin drive enable
    output ppio_pkg::ppio_array_in_t     arrayIn,       // array input bus
    output logic                         arrayStandby   // arrays in standby
);
    import ppio_pkg::*;

    // ------------------------------------------------------------
    // Pin input synchronisers
    // ------------------------------------------------------------
    logic [3:0][7:0] pinStable_q;

    // One filter per port, so the agreement rule lives in one place
    // and every port sees the same latency
    for (genvar p = 0; p < NPORT; p++) begin : g_pin_filter
        ppio_pin_filter #(
            .WIDTH(8)
        ) i_ppio_pin_filter (
            .sys_clk  (sys_clk),
            .reset_n  (reset_n),
            .pinRaw   (pinIn[p]),
            .pinClean (pinStable_q[p])
        );
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [3:0][7:0] dir_q;
    logic [3:0][7:0] dir_d;
    logic [3:0][7:0] dataOut_q;
    logic [3:0][7:0] dataOut_d;
    logic [7:0]      pmFirst_q;
    logic [7:0]      pmFirst_d;
    logic [7:0]      pmThird_q;
    logic [7:0]      pmThird_d;
    logic [7:0]      rdData_q;
    logic [7:0]      rdData_d;

    always_comb begin
        dir_d     = dir_q;
        dataOut_d = dataOut_q;
        pmFirst_d = pmFirst_q;
        pmThird_d = pmThird_q;
        // Unmapped reads return zero, so software never sees stale data
        rdData_d  = 8'h00;
        for (int p = 0; p < NPORT; p++) begin
            // Port D keeps only bits 1 and 2 of its direction
            if (regReq.wr && regReq.addr == OFF_DIR + 8'(p)) begin
                dir_d[p] = regReq.wdata & PORT_PIN_MASK[p];
            end
            // Stored even for array output pins; never reaches them
            if (regReq.wr && regReq.addr == OFF_DATA_OUT + 8'(p)) begin
                dataOut_d[p] = regReq.wdata & PORT_PIN_MASK[p];
            end
            if (regReq.rd && regReq.addr == OFF_DATA_IN + 8'(p)) begin
                rdData_d = pinStable_q[p] & PORT_PIN_MASK[p];
            end
            if (regReq.rd && regReq.addr == OFF_DATA_OUT + 8'(p)) begin
                rdData_d = dataOut_q[p];
            end
            if (regReq.rd && regReq.addr == OFF_DIR + 8'(p)) begin
                rdData_d = dir_q[p];
            end
        end
        if (regReq.wr && regReq.addr == OFF_PMMR_FIRST) begin
            pmFirst_d = regReq.wdata & PMMR_FIRST_MASK;
        end
        if (regReq.wr && regReq.addr == OFF_PMMR_THIRD) begin
            pmThird_d = regReq.wdata & PMMR_THIRD_MASK;
        end
        if (regReq.rd && regReq.addr == OFF_PMMR_FIRST) begin
            rdData_d = pmFirst_q;
        end
        if (regReq.rd && regReq.addr == OFF_PMMR_THIRD) begin
            rdData_d = pmThird_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            dir_q     <= {NPORT{DIR_RESET}};
            dataOut_q <= {NPORT{DATA_OUT_RESET}};
            pmFirst_q <= PMMR_RESET;
            pmThird_q <= PMMR_RESET;
            rdData_q  <= 8'h00;
        end else begin
            dir_q     <= dir_d;
            dataOut_q <= dataOut_d;
            pmFirst_q <= pmFirst_d;
            pmThird_q <= pmThird_d;
            rdData_q  <= rdData_d;
        end
    end

    assign regRdData = rdData_q;

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    logic [3:0][7:0] pinOut_q;
    logic [3:0][7:0] pinOut_d;
    logic [3:0][7:0] pinOe_q;
    logic [3:0][7:0] pinOe_d;
    logic [3:0][7:0] dirEff;

    always_comb begin
        // Direction held off during reset, array enable is not
        dirEff = reset_n ? dir_q : '0;
        for (int p = 0; p < NPORT; p++) begin
            // Array output pins ignore the data-out register
            pinOut_d[p] = (pldOutSel[p] & arrayPinOut[p])
                        | (~pldOutSel[p] & dataOut_q[p]);
            pinOe_d[p]  = (arrayPinOe[p] | dirEff[p])
                        & PORT_PIN_MASK[p];
        end
    end

    // Enable flop is left without reset so an active array enable
    // reaches the pin even while reset is held
    always_ff @(posedge sys_clk) begin
        pinOe_q <= pinOe_d;
        if (!reset_n) begin
            pinOut_q <= '0;
        end else begin
            pinOut_q <= pinOut_d;
        end
    end

    assign pinOut = pinOut_q;
    assign pinOe  = pinOe_q;

    // ------------------------------------------------------------
    // Input macrocells and array input bus
    // ------------------------------------------------------------
    logic [2:0][7:0]  imc_q;
    logic [2:0][7:0]  imc_d;
    ppio_array_in_t   arrayIn_q;
    ppio_array_in_t   arrayIn_d;

    always_comb begin
        for (int p = 0; p < PORT_D; p++) begin
            imc_d[p] = pinStable_q[p] & PORT_PIN_MASK[p];
        end
        arrayIn_d               = '0;
        arrayIn_d.addr          = cpuAddr;
        // Blocked strobe forced low so it cannot stir the arrays
        arrayIn_d.strobe.rd     = cpuStrobe.rd   & ~pmThird_q[BLK_RD_BIT];
        arrayIn_d.strobe.wr     = cpuStrobe.wr   & ~pmThird_q[BLK_WR_BIT];
        arrayIn_d.strobe.program_store_strobe   = cpuStrobe.program_store_strobe & ~pmThird_q[BLK_PROGRAM_STORE_STROBE_BIT];
        arrayIn_d.strobe.ale    = cpuStrobe.ale  & ~pmFirst_q[BLK_ALE_BIT];
        arrayIn_d.coreReset     = coreReset;
        arrayIn_d.autoPowerdown = autoPowerdown;
        arrayIn_d.portA         = imc_q[0];
        arrayIn_d.portB         = imc_q[1];
        arrayIn_d.portC         = {imc_q[2][7], imc_q[2][4:2]};
        // Port D bypasses the macrocell stage
        arrayIn_d.portD         = pinStable_q[PORT_D][2:1];
        arrayIn_d.pageBits      = pageBits;
        arrayIn_d.fbAb          = mcellFbAb;
        arrayIn_d.fbBc          = mcellFbBc;
        arrayIn_d.flashReady    = flashReady;
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            imc_q     <= '0;
            arrayIn_q <= '0;
        end else begin
            imc_q     <= imc_d;
            arrayIn_q <= arrayIn_d;
        end
    end

    // Registered so the arrays and the standby detector see one
    // settled value per cycle
    assign arrayIn = arrayIn_q;

    // ------------------------------------------------------------
    // Automatic standby
    // ------------------------------------------------------------
    logic [4:0] idleCnt_q;
    logic [4:0] idleCnt_d;
    logic       standby_q;
    logic       standby_d;
    logic       turboOn;
    logic       inputsMoved;

    // Movement is judged behind the blocking gates, so a blocked
    // strobe that keeps toggling never restarts the count
    // Counter saturates so a long quiet spell cannot wrap it
    always_comb begin
        turboOn     = ~pmFirst_q[TURBO_BIT];
        inputsMoved = (arrayIn_d != arrayIn_q);
        if (turboOn || inputsMoved) begin
            idleCnt_d = 5'h00;
        end else if (idleCnt_q != STANDBY_CYC) begin
            idleCnt_d = idleCnt_q + 5'h01;
        end else begin
            idleCnt_d = idleCnt_q;
        end
        standby_d = (idleCnt_d == STANDBY_CYC);
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            idleCnt_q <= 5'h00;
            standby_q <= 1'b0;
        end else begin
            idleCnt_q <= idleCnt_d;
            standby_q <= standby_d;
        end
    end

    assign arrayStandby = standby_q;

endmodule

// ------------------------------------------------------------
// Pin input filter
// ------------------------------------------------------------
// Four flops per pin. The accepted level only follows once
// stages two and three agree, so a first stage still settling
// or a one-cycle glitch never reaches the registers or arrays.
// Costs extra cycles of latency against a plain two-flop chain.
module ppio_pin_filter #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             sys_clk,  // 250 MHz clock
    input  wire logic             reset_n,  // sync reset
    input  wire logic [WIDTH-1:0] pinRaw,   // asynchronous pin levels
    output logic [WIDTH-1:0]      pinClean  // accepted levels
);
    import ppio_pkg::*;

    logic [WIDTH-1:0] sync1_q;
    logic [WIDTH-1:0] sync2_q;
    logic [WIDTH-1:0] sync3_q;
    logic [WIDTH-1:0] stable_q;
    logic [WIDTH-1:0] stable_d;
    logic [WIDTH-1:0] agree;

    // Hold the last accepted level while the stages disagree
    always_comb begin
        agree    = ~(sync2_q ^ sync3_q);
        stable_d = (sync3_q & agree) | (stable_q & ~agree);
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            sync1_q  <= '0;
            sync2_q  <= '0;
            sync3_q  <= '0;
            stable_q <= '0;
        end else begin
            sync1_q  <= pinRaw;
            sync2_q  <= sync1_q;
            sync3_q  <= sync2_q;
            stable_q <= stable_d;
        end
    end

    assign pinClean = stable_q;

endmodule

// file: ppio_tb.sv
// Self-checking bench for the port I/O control block.
// Assumes the board model closes the pin loop and the checker is bound.
`timescale 1ns/1ns

module tb;
    import ppio_pkg::*;
    logic            sys_clk, reset_n, coreReset, autoPowerdown, flashReady;
    ppio_reg_req_t   regReq;
    logic [7:0]      regRdData, pageBits, mcellFbAb, mcellFbBc;
    logic [15:0]     cpuAddr;
    ppio_strobe_t    cpuStrobe;
    logic [3:0][7:0] pldOutSel, arrayPinOut, arrayPinOe, pinIn, pinOut, pinOe, extLvl, extEn;
    ppio_array_in_t  arrayIn;
    logic            arrayStandby;
    int              err_total, tests_run, n;
    // Address, write data, read-back value
    logic [23:0]     rows [8] = '{24'h15_ff06, 24'hb0_ff0a, 24'hb4_ff38, 24'h20_ff00,
                                  24'h12_a5a5, 24'h15_0000, 24'hb0_0000, 24'hb4_0000};

    ppio_port_io_control i_ppio_port_io_control (.sys_clk(sys_clk), .reset_n(reset_n),
        .regReq(regReq), .regRdData(regRdData), .cpuAddr(cpuAddr), .cpuStrobe(cpuStrobe),
        .coreReset(coreReset), .autoPowerdown(autoPowerdown), .pageBits(pageBits),
        .mcellFbAb(mcellFbAb), .mcellFbBc(mcellFbBc), .flashReady(flashReady),
        .pldOutSel(pldOutSel), .arrayPinOut(arrayPinOut), .arrayPinOe(arrayPinOe),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .arrayIn(arrayIn),
        .arrayStandby(arrayStandby));
    ppio_board_model i_ppio_board_model (.pinOut(pinOut), .pinOe(pinOe),
        .extLvl(extLvl), .extEn(extEn), .pinIn(pinIn));

    always #2 sys_clk = ~sys_clk;

    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic step(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        step(1);
        regReq = '0;
        step(1);
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        regReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        step(1);
        chk(what, exp, regRdData);
        regReq = '0;
        step(1);
    endtask
    task automatic end_sim();
        if (err_total == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wait_sb();
        n = 0;
        while (arrayStandby !== 1'b1 && n < 40) begin
            step(1);
            n++;
        end
        if (arrayStandby !== 1'b1) begin
            chk("standbyWait", 8'h01, 8'h00);
            end_sim();
        end
    endtask

    initial begin
        sys_clk = 1'b0;
        reset_n = 1'b0;
        regReq = '0;
        cpuAddr = 16'h1234;
        cpuStrobe = '0;
        coreReset = 1'b0;
        autoPowerdown = 1'b1;
        flashReady = 1'b1;
        pageBits = 8'h5a;
        mcellFbAb = 8'h3c;
        mcellFbBc = 8'hc3;
        {pldOutSel, arrayPinOut, arrayPinOe, extLvl} = '0;
        extEn = '1;
        err_total = 0;
        tests_run = 0;
        step(10);
        reset_n = 1'b1;
        step(1);
        foreach (rows[i]) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rdchk("regRow", rows[i][23:16], rows[i][7:0]);
        end
        chk("pageBits", 8'h5a, arrayIn.pageBits);
        chk("fbAb", 8'h3c, arrayIn.fbAb);
        chk("fbBc", 8'hc3, arrayIn.fbBc);
        chk("ctrlBits", 8'h03,
            8'({arrayIn.coreReset, arrayIn.autoPowerdown, arrayIn.flashReady}));
        wr(8'h04, 8'h01);
        chk("oeDir", 8'h01, 8'(pinOe[0][0]));
        chk("outDir", 8'h01, 8'(pinOut[0][0]));
        step(5);
        rdchk("dataInA", 8'h00, 8'h01);
        pldOutSel[0][1] = 1'b1;
        arrayPinOut[0][1] = 1'b1;
        arrayPinOe[0][1] = 1'b1;
        step(2);
        chk("pldLevel", 8'h01, 8'(pinOut[0][1]));
        chk("pldOe", 8'h01, 8'(pinOe[0][1]));
        arrayPinOut[0][1] = 1'b0;
        wr(8'h04, 8'hff);
        chk("pldIgnoresOut", 8'h00, 8'(pinOut[0][1]));
        rdchk("dataOutA", 8'h04, 8'hff);
        extLvl[3][1] = 1'b1;
        extLvl[2][7] = 1'b1;
        extLvl[1][3] = 1'b1;
        step(5);
        chk("directD", 8'h01, 8'(arrayIn.portD[0]));
        chk("cellB", 8'h00, 8'(arrayIn.portB[3]));
        step(1);
        chk("cellBLate", 8'h01, 8'(arrayIn.portB[3]));
        chk("cellC", 8'h08, 8'(arrayIn.portC));
        wr(8'hb0, 8'h08);
        wait_sb();
        chk("standbyLate", 8'h01, 8'(n >= 15));
        wr(8'hb4, 8'h38);
        wr(8'hb0, 8'h0a);
        cpuStrobe = '1;
        step(3);
        chk("blockedQuiet", 8'h01, 8'(arrayStandby));
        cpuAddr = 16'h4321;
        step(2);
        chk("wake", 8'h00, 8'(arrayStandby));
        wait_sb();
        wr(8'hb0, 8'h00);
        chk("turboOn", 8'h00, 8'(arrayStandby));
        reset_n = 1'b0;
        arrayPinOe[1][0] = 1'b1;
        step(10);
        chk("resetOe", 8'h01, 8'(pinOe[1][0]));
        reset_n = 1'b1;
        step(1);
        rdchk("dirAReset", 8'h12, 8'h00);
        rdchk("pwrReset", 8'hb0, 8'h00);
        end_sim();
    end
endmodule
